// file: pcihs_pkg.sv
/*
  shared constants and carrier types for the pci pin control and hot-swap block.
  assumes one 20 MHz clock and an active-low asynchronous reset.
*/
package pcihs_pkg;
  // ----------------------------------------------------------------
  // parity and bus widths
  // ----------------------------------------------------------------
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  // special cycle command code on c/be#
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  // ----------------------------------------------------------------
  // error report timing
  // ----------------------------------------------------------------
  localparam int ERR_REPORT_DELAY_CLK = 2;
  localparam int ERR_HOLD_CLK = 1;
  localparam int CLOCK_HZ = 20_000_000;
  localparam int CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;

  // hot-swap connection stages
  typedef enum logic [1:0] {
    PCIHS_POWER_DOWN,
    PCIHS_HW_CONNECT,
    PCIHS_SW_CONNECT,
    PCIHS_NORMAL
  } pcihs_stage_t;

  // sampled address/data phase
  typedef struct packed {
    logic [AD_W-1:0] ad;
    logic [CBE_W-1:0] cbe_n;
    logic par;
  } pcihs_phase_t;

  // open-drain / tri-state pin drive
  typedef struct packed {
    logic o;
    logic oe;
  } pcihs_pin_t;
endpackage

// file: pcihs_pin_ctrl.sv
/*
  pci-side pin control: parity checking with perr#/serr# reporting, req#/gnt#
  direction by arbiter mode, stop#/trdy# target and master use, and hot-swap
  event, led, healthy and ejector latch handling.
  assumes pci pins are synchronous to clock, except the hot-swap inputs, which
  are synchronised here. bidirectional pins are split into in/out/oe.
*/
// How it works
// - perr# asserted within two clocks of errored received data.
// - perr# held at least one clock per errored data phase.
// - special cycles never raise perr#; all other transactions checked.
// - serr# asserted within two clocks of an address parity error.
// - serr# held at least one clock per errored phase.
// - with an outside arbiter, req# is driven as our bus request.
// - with the internal arbiter, req# is an input sampled by it.
// - rst# asynchronously forces registers and states to initial values; stop#/trdy# enables still follow target_selected.
// - as target, stop# asserted when we must end the transaction.
// - as master, we end our transaction when the target asserts stop#.
// - as target, trdy# asserted when we can complete the data phase.
// - open-drain event output flags board insertion or pending removal.
// - healthy input ORed with reset; power stable only when both released.
// - led pin driven low during hardware and software connection stages.
// - led pin released to high impedance in normal operation.
// - ejector latch input low means open, high means closed.
// - parity even across ad, c/be# and par; used for check and generation.
// - as arbiter, gnt# driven to grant the external requester.
// - arbiter strap sampled at reset release; high selects internal arbiter.
`timescale 1ns/1ps
`default_nettype none
module pcihs_pin_ctrl #(
  parameter int AD_W = pcihs_pkg::AD_W
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic internal_arbiter_select,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  input wire logic [AD_W-1:0] ad_in,
  input wire logic [3:0] cbe_n_in,
  input wire logic par_in,
  input wire logic trdy_n_in,
  input wire logic stop_n_in,
  input wire logic devsel_n_in,
  input wire logic req_n_in,
  input wire logic gnt_n_in,
  input wire logic [AD_W-1:0] out_ad,
  input wire logic [3:0] out_cbe_n,
  input wire logic master_request,
  input wire logic master_active,
  input wire logic master_is_read,
  input wire logic target_selected,
  input wire logic target_ready,
  input wire logic target_stop,
  input wire logic insert_event,
  input wire logic extract_event,
  input wire logic event_ack,
  input wire logic software_connected,
  input wire logic backend_power_good_n,
  input wire logic ejector_latch_closed,
  output logic perr_n_out,
  output logic perr_n_oe,
  output logic serr_n_out,
  output logic serr_n_oe,
  output logic par_out,
  output logic req_n_out,
  output logic req_n_oe,
  output logic gnt_n_out,
  output logic gnt_n_oe,
  output logic stop_n_out,
  output logic stop_n_oe,
  output logic trdy_n_out,
  output logic trdy_n_oe,
  output logic enum_n_out,
  output logic enum_n_oe,
  output logic swap_indicator_led_n_out,
  output logic swap_indicator_led_n_oe,
  output logic arbiter_internal,
  output logic master_terminate,
  output logic [AD_W-1:0] read_data,
  output logic read_data_valid,
  output logic backend_power_stable,
  output logic latch_closed,
  output logic bus_request_seen,
  output pcihs_pkg::pcihs_stage_t stage
);
  // ----------------------------------------------------------------
  // parity check and generation
  // ----------------------------------------------------------------
  pcihs_pkg::pcihs_phase_t phase_reg;
  logic addr_phase_reg;
  logic data_phase_reg;
  logic special_reg;
  logic cmd_special_reg;
  logic frame_d_reg;
  logic perr_reg;
  logic serr_reg;
  logic par_reg;

  // address phase is the first cycle frame# is low
  wire addr_phase = !frame_n_in && frame_d_reg;
  wire data_phase = !irdy_n_in && (!trdy_n_in || (target_selected && target_ready));
  // par lags ad/cbe by one clock, so check the stored phase against the present par
  wire parity_bad = ^{phase_reg.ad, phase_reg.cbe_n, par_in};
  wire is_special = (cbe_n_in == pcihs_pkg::CMD_SPECIAL);
  wire perr_next = data_phase_reg && !special_reg && parity_bad;
  wire serr_next = addr_phase_reg && parity_bad;
  wire par_next = ^{out_ad, out_cbe_n};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= '0;
      addr_phase_reg <= 1'b0;
      data_phase_reg <= 1'b0;
      special_reg <= 1'b0;
      cmd_special_reg <= 1'b0;
      frame_d_reg <= 1'b1;
      perr_reg <= 1'b0;
      serr_reg <= 1'b0;
      par_reg <= 1'b0;
    end else begin
      phase_reg <= '{ad: ad_in, cbe_n: cbe_n_in, par: par_in};
      addr_phase_reg <= addr_phase;
      data_phase_reg <= data_phase;
      frame_d_reg <= frame_n_in;
      if (addr_phase) begin
        cmd_special_reg <= is_special;
      end
      special_reg <= addr_phase ? is_special : cmd_special_reg;
      perr_reg <= perr_next;
      serr_reg <= serr_next;
      par_reg <= par_next;
    end
  end

  assign perr_n_out = 1'b0;
  assign perr_n_oe = perr_reg;
  assign serr_n_out = 1'b0;
  assign serr_n_oe = serr_reg;
  assign par_out = par_reg;

  a_perr_timing: assert property (@(posedge clock) disable iff (!nrst)
    (data_phase && !special_reg && !addr_phase && !is_special) ##1 parity_bad
      |-> ##1 perr_n_oe) else $error("perr not raised for data parity error");
  a_perr_special: assert property (@(posedge clock) disable iff (!nrst)
    $rose(perr_n_oe) |-> !$past(special_reg)) else $error("perr on special cycle");
  a_serr_timing: assert property (@(posedge clock) disable iff (!nrst)
    addr_phase ##1 parity_bad |-> ##1 serr_n_oe) else $error("serr not raised in time");
  a_serr_drive: assert property (@(posedge clock) disable iff (!nrst)
    serr_n_oe |-> $past(addr_phase_reg)) else $error("serr without address phase");

  // ----------------------------------------------------------------
  // arbitration mode and req#/gnt#
  // ----------------------------------------------------------------
  logic strap_taken_reg;
  logic arb_int_reg;
  logic req_reg;
  logic gnt_reg;
  logic req_seen_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strap_taken_reg <= 1'b0;
      arb_int_reg <= 1'b0;
      req_reg <= 1'b0;
      gnt_reg <= 1'b0;
      req_seen_reg <= 1'b0;
    end else begin
      // strap caught on the first edge after release, then frozen
      strap_taken_reg <= 1'b1;
      if (!strap_taken_reg) begin
        arb_int_reg <= internal_arbiter_select;
      end
      req_reg <= master_request && !arb_int_reg;
      req_seen_reg <= arb_int_reg && !req_n_in;
      // simple arbiter: grant the external requester while we do not need the bus
      gnt_reg <= arb_int_reg && !req_n_in && !master_request && frame_n_in;
    end
  end

  assign arbiter_internal = arb_int_reg;
  assign bus_request_seen = req_seen_reg;
  assign req_n_out = 1'b0;
  assign req_n_oe = req_reg;
  assign gnt_n_out = 1'b0;
  assign gnt_n_oe = gnt_reg;

  a_req_input: assert property (@(posedge clock) disable iff (!nrst)
    arb_int_reg |-> ##1 !req_n_oe) else $error("req driven with internal arbiter");
  a_req_drive: assert property (@(posedge clock) disable iff (!nrst)
    (master_request && !arb_int_reg && strap_taken_reg) |=> req_n_oe)
    else $error("req not driven for own request");
  a_gnt_mode: assert property (@(posedge clock) disable iff (!nrst)
    gnt_n_oe |-> $past(arb_int_reg) && $past(!req_n_in))
    else $error("gnt without request or arbiter");

  // ----------------------------------------------------------------
  // target stop#/trdy# and master termination, read capture
  // ----------------------------------------------------------------
  logic stop_reg;
  logic trdy_reg;
  logic term_reg;
  logic rd_valid_reg;
  logic [AD_W-1:0] rd_data_reg;

  wire master_rd_phase = master_active && master_is_read && !irdy_n_in && !trdy_n_in;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stop_reg <= 1'b0;
      trdy_reg <= 1'b0;
      term_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= '0;
    end else begin
      stop_reg <= target_selected && target_stop;
      trdy_reg <= target_selected && target_ready;
      term_reg <= master_active && !stop_n_in && !devsel_n_in;
      rd_valid_reg <= master_rd_phase;
      if (master_rd_phase) begin
        rd_data_reg <= ad_in;
      end
    end
  end

  assign stop_n_out = !stop_reg;
  assign stop_n_oe = target_selected || stop_reg;
  assign trdy_n_out = !trdy_reg;
  assign trdy_n_oe = target_selected || trdy_reg;
  assign master_terminate = term_reg;
  assign read_data = rd_data_reg;
  assign read_data_valid = rd_valid_reg;

  a_stop_target: assert property (@(posedge clock) disable iff (!nrst)
    (target_selected && target_stop) |=> (stop_n_oe && !stop_n_out))
    else $error("stop not asserted as target");
  a_master_term: assert property (@(posedge clock) disable iff (!nrst)
    (master_active && !stop_n_in && !devsel_n_in) |=> master_terminate)
    else $error("master did not end on stop");
  a_read_capture: assert property (@(posedge clock) disable iff (!nrst)
    master_rd_phase |=> (read_data_valid && read_data == $past(ad_in)))
    else $error("read data not captured");

  // ----------------------------------------------------------------
  // hot-swap: synchronisers, power, stages, led and event
  // ----------------------------------------------------------------
  logic [1:0] good_sync_reg;
  logic [1:0] latch_sync_reg;
  logic event_reg;
  pcihs_pkg::pcihs_stage_t stage_reg;
  pcihs_pkg::pcihs_stage_t stage_next;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      good_sync_reg <= 2'b11;
      latch_sync_reg <= 2'b00;
    end else begin
      good_sync_reg <= {good_sync_reg[0], backend_power_good_n};
      latch_sync_reg <= {latch_sync_reg[0], ejector_latch_closed};
    end
  end

  // reset is held in the flops, so a synchronised low here means both released
  wire power_ok = !(good_sync_reg[1] || !nrst);
  wire latch_is_closed = latch_sync_reg[1];

  always_comb begin
    stage_next = stage_reg;
    case (stage_reg)
      pcihs_pkg::PCIHS_POWER_DOWN: begin
        if (power_ok) begin
          stage_next = pcihs_pkg::PCIHS_HW_CONNECT;
        end
      end
      pcihs_pkg::PCIHS_HW_CONNECT: begin
        if (!power_ok) begin
          stage_next = pcihs_pkg::PCIHS_POWER_DOWN;
        end else if (latch_is_closed) begin
          stage_next = pcihs_pkg::PCIHS_SW_CONNECT;
        end
      end
      pcihs_pkg::PCIHS_SW_CONNECT: begin
        if (!power_ok) begin
          stage_next = pcihs_pkg::PCIHS_POWER_DOWN;
        end else if (software_connected) begin
          stage_next = pcihs_pkg::PCIHS_NORMAL;
        end
      end
      pcihs_pkg::PCIHS_NORMAL: begin
        if (!power_ok) begin
          stage_next = pcihs_pkg::PCIHS_POWER_DOWN;
        end else if (!latch_is_closed) begin
          stage_next = pcihs_pkg::PCIHS_SW_CONNECT;
        end
      end
      default: begin
        stage_next = pcihs_pkg::PCIHS_POWER_DOWN;
      end
    endcase
  end

  // a new event wins over an acknowledge in the same cycle
  wire event_next = insert_event || extract_event || (event_reg && !event_ack);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage_reg <= pcihs_pkg::PCIHS_POWER_DOWN;
      event_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      event_reg <= event_next;
    end
  end

  wire led_on = (stage_reg == pcihs_pkg::PCIHS_HW_CONNECT) ||
                (stage_reg == pcihs_pkg::PCIHS_SW_CONNECT);

  assign stage = stage_reg;
  assign backend_power_stable = power_ok;
  assign latch_closed = latch_is_closed;
  assign enum_n_out = 1'b0;
  assign enum_n_oe = event_reg;
  assign swap_indicator_led_n_out = 1'b0;
  assign swap_indicator_led_n_oe = led_on;

  a_led_stage: assert property (@(posedge clock) disable iff (!nrst)
    (stage == pcihs_pkg::PCIHS_NORMAL) |-> !swap_indicator_led_n_oe)
    else $error("led driven in normal operation");
  a_led_connect: assert property (@(posedge clock) disable iff (!nrst)
    (stage == pcihs_pkg::PCIHS_HW_CONNECT) |-> swap_indicator_led_n_oe)
    else $error("led off during connection");
  a_event_set: assert property (@(posedge clock) disable iff (!nrst)
    (insert_event || extract_event) |=> enum_n_oe)
    else $error("event output not asserted");
  a_power_gate: assert property (@(posedge clock) disable iff (!nrst)
    $past(backend_power_good_n, 2) && $past(backend_power_good_n) |-> !backend_power_stable)
    else $error("power stable while healthy high");
endmodule
`default_nettype wire

// file: pcihs_bus_model.sv
/*
  far-side pci agent: address and data phases, parity, target handshake and
  an outside bus request. assumes the bench moves its controls at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module pcihs_bus_model (
  input wire logic clock,
  input wire logic go,
  input wire logic addr_phase,
  input wire logic [31:0] phase_ad,
  input wire logic [3:0] phase_cbe_n,
  input wire logic bad_par,
  input wire logic tgt_stop,
  input wire logic ext_req,
  output logic frame_n_in,
  output logic irdy_n_in,
  output logic devsel_n_in,
  output logic trdy_m,
  output logic stop_m,
  output logic req_m,
  output logic [31:0] ad_in,
  output logic [3:0] cbe_n_in,
  output var logic par_in
);
  logic [35:0] last_reg = 36'h0_0000_0000;
  logic par_next = 1'b0;
  // a released bus shows the inverse of its last value, never a stale copy
  assign {ad_in, cbe_n_in} = go ? {phase_ad, phase_cbe_n} : ~last_reg;
  assign frame_n_in = ~(go & addr_phase);
  assign irdy_n_in = ~(go & ~addr_phase);
  // a target that signals stop has claimed the cycle, so devsel# goes with it
  assign devsel_n_in = irdy_n_in & ~tgt_stop;
  assign trdy_m = irdy_n_in;
  assign stop_m = ~tgt_stop;
  assign req_m = ~ext_req;
  initial par_in = 1'b0;
  always @(posedge clock) begin
    last_reg <= {ad_in, cbe_n_in};
    par_next <= ^{ad_in, cbe_n_in} ^ (go & bad_par);
  end
  // par trails its phase by one clock and moves off the sampling edge
  always @(negedge clock) par_in <= par_next;
endmodule
`default_nettype wire

// file: tb_top.sv
/*
  self-checking bench for pcihs_pin_ctrl facing the far-side model.
  assumes one 50 ns clock; stimulus moves on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic internal_arbiter_select = 1'b0;
  logic go = 1'b0, addr_phase = 1'b0, bad_par = 1'b0, tgt_stop = 1'b0, ext_req = 1'b0;
  logic [31:0] phase_ad = 32'h0000_0000, out_ad = 32'h0000_0000, ad_in, read_data;
  logic [3:0] phase_cbe_n = 4'h0, out_cbe_n = 4'h0, cbe_n_in;
  logic master_request = 1'b0, master_active = 1'b0, master_is_read = 1'b0;
  logic target_selected = 1'b0, target_ready = 1'b0, target_stop = 1'b0;
  logic insert_event = 1'b0, extract_event = 1'b0, event_ack = 1'b0;
  logic software_connected = 1'b0, backend_power_good_n = 1'b1, ejector_latch_closed = 1'b0;
  logic frame_n_in, irdy_n_in, devsel_n_in, par_in, trdy_m, stop_m, req_m, prev_stop;
  logic perr_n_out, perr_n_oe, serr_n_out, serr_n_oe, par_out, req_n_out, req_n_oe;
  logic gnt_n_out, gnt_n_oe, stop_n_out, stop_n_oe, trdy_n_out, trdy_n_oe;
  logic enum_n_out, enum_n_oe, swap_indicator_led_n_out, swap_indicator_led_n_oe;
  logic arbiter_internal, master_terminate, read_data_valid, backend_power_stable;
  logic latch_closed, bus_request_seen;
  logic [4:0] r;
  pcihs_pkg::pcihs_stage_t stage;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  // shared lines carry every party's pull-down
  wire logic stop_n_in = stop_m & ~(stop_n_oe & ~stop_n_out);
  wire logic trdy_n_in = trdy_m & ~(trdy_n_oe & ~trdy_n_out);
  wire logic req_n_in = req_m & ~(req_n_oe & ~req_n_out);
  wire logic gnt_n_in = ~(gnt_n_oe & ~gnt_n_out);

  pcihs_bus_model pcihs_bus_model_i (.clock, .go, .addr_phase, .phase_ad, .phase_cbe_n,
    .bad_par, .tgt_stop, .ext_req, .frame_n_in, .irdy_n_in, .devsel_n_in, .trdy_m, .stop_m,
    .req_m, .ad_in, .cbe_n_in, .par_in);
  pcihs_pin_ctrl pcihs_pin_ctrl_i (.clock, .nrst, .internal_arbiter_select, .frame_n_in,
    .irdy_n_in, .ad_in, .cbe_n_in, .par_in, .trdy_n_in, .stop_n_in, .devsel_n_in, .req_n_in,
    .gnt_n_in, .out_ad, .out_cbe_n, .master_request, .master_active, .master_is_read,
    .target_selected, .target_ready, .target_stop, .insert_event, .extract_event, .event_ack,
    .software_connected, .backend_power_good_n, .ejector_latch_closed, .perr_n_out, .perr_n_oe,
    .serr_n_out, .serr_n_oe, .par_out, .req_n_out, .req_n_oe, .gnt_n_out, .gnt_n_oe,
    .stop_n_out, .stop_n_oe, .trdy_n_out, .trdy_n_oe, .enum_n_out, .enum_n_oe,
    .swap_indicator_led_n_out, .swap_indicator_led_n_oe, .arbiter_internal, .master_terminate,
    .read_data, .read_data_valid, .backend_power_stable, .latch_closed, .bus_request_seen,
    .stage);

  // ----------------------------------------------------------------
  // compare and helper tasks
  // ----------------------------------------------------------------
  function automatic logic low(input logic oe, input logic o);
    return oe & ~o;
  endfunction
  task automatic note(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      error_cnt++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    note(got === exp, msg);
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    note(got === exp, msg);
  endtask
  task automatic chk_stage(input pcihs_pkg::pcihs_stage_t exp, input string msg);
    note(stage === exp, msg);
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk_reset(input string msg);
    chk_word({13'h0, perr_n_oe, serr_n_oe, req_n_oe, gnt_n_oe, stop_n_oe, trdy_n_oe, enum_n_oe,
      swap_indicator_led_n_oe, backend_power_stable, latch_closed, par_out, read_data_valid,
      master_terminate, arbiter_internal, bus_request_seen, perr_n_out, serr_n_out,
      enum_n_out, swap_indicator_led_n_out}, 32'h0000_0000, msg);
    chk_stage(pcihs_pkg::PCIHS_POWER_DOWN, msg);
  endtask
  // address phase then a master-read data phase, parity faults on request
  task automatic txn(input logic [3:0] cmd, input logic abad, input logic dbad);
    logic [31:0] d;
    logic s2, p3;
    int ns, np;
    d = $urandom;
    ns = 0;
    np = 0;
    {go, addr_phase, phase_ad, phase_cbe_n, bad_par} = {2'b11, 32'($urandom), cmd, abad};
    tick(1);
    {addr_phase, phase_ad, phase_cbe_n, bad_par} = {1'b0, d, 4'($urandom), dbad};
    {master_active, master_is_read} = 2'b11;
    tick(1);
    {go, bad_par, master_active, master_is_read} = 4'h0;
    chk_bit(read_data_valid, 1'b1, "read data not flagged");
    chk_word(read_data, d, "read data");
    for (int i = 1; i < 7; i++) begin
      if (i == 1) s2 = low(serr_n_oe, serr_n_out);
      if (i == 2) p3 = low(perr_n_oe, perr_n_out);
      ns += int'(low(serr_n_oe, serr_n_out));
      np += int'(low(perr_n_oe, perr_n_out));
      tick(1);
    end
    chk_bit(s2, abad, "address error timing");
    chk_word(ns, {31'h0, abad}, "address error count");
    chk_bit(p3, dbad & (cmd != pcihs_pkg::CMD_SPECIAL), "data error timing");
    chk_word(np, {31'h0, dbad & (cmd != pcihs_pkg::CMD_SPECIAL)}, "data error count");
  endtask

  initial begin
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1500) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(25532));
    tick(19);
    chk_reset("reset state");
    tick(1);
    nrst = 1'b1;
    tick(4);
    chk_bit(backend_power_stable, 1'b0, "stable while unhealthy");
    backend_power_good_n = 1'b0;
    tick(4);
    chk_bit(backend_power_stable, 1'b1, "power not stable");
    chk_bit(low(swap_indicator_led_n_oe, swap_indicator_led_n_out), 1'b1, "led hw");
    ejector_latch_closed = 1'b1;
    tick(4);
    chk_bit(latch_closed, 1'b1, "latch closed");
    chk_stage(pcihs_pkg::PCIHS_SW_CONNECT, "sw stage");
    chk_bit(low(swap_indicator_led_n_oe, swap_indicator_led_n_out), 1'b1, "led sw");
    software_connected = 1'b1;
    tick(2);
    chk_stage(pcihs_pkg::PCIHS_NORMAL, "normal stage");
    chk_bit(swap_indicator_led_n_oe, 1'b0, "led in normal");
    {software_connected, ejector_latch_closed} = 2'b00;
    tick(4);
    chk_bit(latch_closed, 1'b0, "latch open");
    {insert_event, ejector_latch_closed} = 2'b11;
    tick(1);
    insert_event = 1'b0;
    tick(3);
    chk_bit(low(enum_n_oe, enum_n_out), 1'b1, "insert event");
    {extract_event, event_ack} = 2'b11;
    tick(1);
    chk_bit(low(enum_n_oe, enum_n_out), 1'b1, "event lost to ack");
    {extract_event, event_ack} = 2'b01;
    tick(1);
    event_ack = 1'b0;
    tick(1);
    chk_bit(enum_n_oe, 1'b0, "event kept");
    repeat (40) begin
      prev_stop = low(stop_n_oe, stop_n_out);
      r = 5'($urandom);
      {target_selected, target_ready, target_stop, tgt_stop} = r[3:0];
      // our own stop# on the shared line is not a far target's stop
      master_active = r[4] & ~r[3] & ~prev_stop;
      {out_ad, out_cbe_n} = {32'($urandom), 4'($urandom)};
      tick(1);
      chk_bit(low(stop_n_oe, stop_n_out), target_selected & target_stop, "stop");
      chk_bit(low(trdy_n_oe, trdy_n_out), target_selected & target_ready, "trdy");
      chk_bit(master_terminate, master_active & tgt_stop, "end");
      chk_bit(par_out, ^{out_ad, out_cbe_n}, "par out");
    end
    {target_selected, target_ready, target_stop, tgt_stop, master_active} = 5'h00;
    tick(2);
    repeat (24) txn(4'($urandom), 1'($urandom), 1'($urandom));
    txn(pcihs_pkg::CMD_SPECIAL, 1'b1, 1'b1);
    backend_power_good_n = 1'b1;
    tick(4);
    chk_bit(backend_power_stable, 1'b0, "stable after health loss");
    master_request = 1'b1;
    tick(2);
    chk_bit(arbiter_internal, 1'b0, "strap low");
    chk_bit(low(req_n_oe, req_n_out), 1'b1, "no request");
    {master_request, nrst, internal_arbiter_select} = 3'b001;
    #1;
    chk_reset("mid-run reset");
    tick(1);
    nrst = 1'b1;
    tick(1);
    {internal_arbiter_select, ext_req} = 2'b01;
    tick(2);
    chk_bit(arbiter_internal, 1'b1, "strap not taken");
    chk_bit(bus_request_seen, 1'b1, "request unseen");
    chk_bit(low(gnt_n_oe, gnt_n_out), 1'b1, "no grant");
    {master_request, ext_req} = 2'b10;
    tick(2);
    chk_bit(req_n_oe, 1'b0, "req driven as input");
    chk_bit(low(gnt_n_oe, gnt_n_out), 1'b0, "stray grant");
    give_verdict();
  end
endmodule
`default_nettype wire
